// [hw/rsm_pkg.sv]
`default_nettype none
package rsm_pkg;

  // Sizes
  localparam int NUM_RAILS = 10;  // Rails sequenced
  localparam int NMON      = 13;  // Analog monitor inputs
  localparam int NCH       = 14;  // Inputs plus on-chip sensor
  localparam int NCMP      = 6;   // Inputs with fast comparators
  localparam int NUM_RW    = 9;   // Writable words per rail

  // Timing
  localparam int CLK_MHZ    = 250;
  localparam int SAMPLE_US  = 400;  // Sequencing loop period
  localparam int CUR_US     = 200;  // One rail current per slot
  localparam int MS_US      = 1000;
  localparam int SAMPLE_CYC = SAMPLE_US * CLK_MHZ;
  localparam int CUR_CYC    = CUR_US * CLK_MHZ;
  localparam int MS_CYC     = MS_US * CLK_MHZ;
  localparam logic [15:0] MAX_DLY_MS = 16'h0ccc;  // 3276 ms

  // Converter
  localparam int LSB_UV  = 610;  // True step of 12-bit code
  localparam int CLAMP_MV = 200;
  localparam logic [11:0] CLAMP_CODE =
    12'((CLAMP_MV * 1000 + LSB_UV - 1) / LSB_UV);
  localparam logic [3:0] CLAMP_FIRST = 4'h9;  // Four clamped inputs

  // Banks and words (address = bank, word)
  localparam logic [3:0] B_MON = 4'ha, B_CMP = 4'hb, B_GLB = 4'hf;
  localparam logic [3:0] R_CFG = 4'h0, R_LINK = 4'h1, R_DLY = 4'h2;
  localparam logic [3:0] R_LIM = 4'h3, R_PG = 4'h4, R_ILIM = 4'h5;
  localparam logic [3:0] R_IWARN = 4'h6, R_ICAL = 4'h7;
  localparam logic [3:0] R_VSCL = 4'h8, R_STAT = 4'hc;
  localparam logic [3:0] R_VOUT = 4'hd, R_IOUT = 4'he;
  localparam logic [3:0] G_CTRL = 4'h0, G_STAT = 4'h1;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam int CTRL_AUTO = 0, CTRL_ON = 1, CTRL_SOFT = 2;

  // Monitor input word fields
  localparam int MC_TYPE = 0, MC_RAIL = 2, MC_CMP = 6;
  localparam logic [1:0] MT_NONE = 2'h0, MT_VOLT = 2'h1;
  localparam logic [1:0] MT_CUR = 2'h2, MT_TEMP = 2'h3;

  // Trigger bit positions
  localparam int ON_OP = 0, ON_PIN = 1, ON_PAR = 2, ON_GIN = 3;
  localparam int OFF_OP = 0, OFF_PIN = 1, OFF_PAR = 2;
  localparam int OFF_FLT = 3, OFF_SLV = 4, OFF_GIN = 5;

  typedef struct packed {
    logic [15:0] rsv;
    logic        imm_off;   // Skip turn-off delay
    logic        vmon;      // Rail has a voltage monitor
    logic        gin_lvl;   // Input level that means on
    logic [2:0]  gin_sel;   // Which general input
    logic [5:0]  off_trig;  // Turn-off causes
    logic [3:0]  on_trig;   // Turn-on conditions
  } rsm_cfg_t;

  typedef struct packed {
    logic        valid;  // One-cycle result strobe
    logic [3:0]  ch;     // Channel converted
    logic [11:0] data;   // Raw code
  } rsm_adc_t;

  typedef enum logic [2:0] {
    S_OFF, S_ONDLY, S_RAMP, S_ON, S_OFFDLY, S_FALL
  } rsm_state_t;

endpackage
`default_nettype wire

// [hw/rsm_sequencer.sv]
`timescale 1ns/100ps
`default_nettype none
module rsm_sequencer #(
  parameter int NR         = rsm_pkg::NUM_RAILS,
  parameter int SAMPLE_CYC = rsm_pkg::SAMPLE_CYC,
  parameter int CUR_CYC    = rsm_pkg::CUR_CYC,
  parameter int MS_CYC     = rsm_pkg::MS_CYC
)(
  input  wire logic                ref_clk,
  input  wire logic                rst_b,
  input  wire logic [7:0]          addr,
  input  wire logic [31:0]         wdata,
  input  wire logic                wr,
  input  wire logic                rd,
  output logic [31:0]              rdata,
  input  wire logic                host_control_pin,
  input  wire logic [7:0]          general_input,
  input  wire rsm_pkg::rsm_adc_t   adc_in,
  output logic [3:0]               adc_sel,
  output logic [NR-1:0]            rail_en,
  output logic [5:0]               general_output
);
  import rsm_pkg::*;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  localparam int SW = $clog2(SAMPLE_CYC);
  localparam int CW = $clog2(CUR_CYC);
  localparam int MW = $clog2(MS_CYC);

  // Timebase counters and their one-cycle ticks
  logic [SW-1:0] smp_cnt;
  logic [CW-1:0] cur_cnt;
  logic [MW-1:0] ms_cnt;
  logic          tick;      // Sequencing sample
  logic          cur_tick;  // Current slot
  logic          ms_tick;   // Delay unit
  wire smp_end = smp_cnt == SW'(SAMPLE_CYC - 1);
  wire cur_end = cur_cnt == CW'(CUR_CYC - 1);
  wire ms_end  = ms_cnt == MW'(MS_CYC - 1);

  // Free-running dividers
  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b)
    begin
      smp_cnt  <= '0;
      cur_cnt  <= '0;
      ms_cnt   <= '0;
      tick     <= 1'b0;
      cur_tick <= 1'b0;
      ms_tick  <= 1'b0;
    end
    else
    begin
      smp_cnt  <= smp_end ? '0 : smp_cnt + SW'(1);
      cur_cnt  <= cur_end ? '0 : cur_cnt + CW'(1);
      ms_cnt   <= ms_end ? '0 : ms_cnt + MW'(1);
      tick     <= smp_end;
      cur_tick <= cur_end;
      ms_tick  <= ms_end;
    end

  // Register storage
  logic [31:0] rreg [NR][NUM_RW];  // Per-rail setup words
  logic [31:0] mcfg [NMON];        // Input assignment
  logic [31:0] cmp_uv [NCMP];      // Fault [11:0], warn [27:16]
  logic [31:0] cmp_ov [NCMP];
  logic [31:0] ctrl;               // Auto, on, soft stop

  // Address decode
  wire [3:0] bank    = addr[7:4];
  wire [3:0] reg_ix  = addr[3:0];
  wire rail_hit      = bank < 4'(NR);
  wire [3:0] rail_ix = rail_hit ? bank : 4'h0;
  wire wr_rail = wr && rail_hit && reg_ix < 4'(NUM_RW);
  wire wr_mon  = wr && bank == B_MON && reg_ix < 4'(NMON);
  wire wr_cmp  = wr && bank == B_CMP && reg_ix < 4'(2 * NCMP);
  wire wr_ctrl = wr && bank == B_GLB && reg_ix == G_CTRL;

  // Writes; nothing else changes setup words
  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b)
    begin
      for (int i = 0; i < NR; i++)
        for (int j = 0; j < NUM_RW; j++)
          rreg[i][j] <= '0;
      for (int i = 0; i < NMON; i++)
        mcfg[i] <= '0;
      for (int i = 0; i < NCMP; i++)
      begin
        cmp_uv[i] <= '0;
        cmp_ov[i] <= '0;
      end
      ctrl <= CTRL_RST;
    end
    else
    begin
      if (wr_rail)
        rreg[rail_ix][reg_ix] <= wdata;
      if (wr_mon)
        mcfg[reg_ix] <= wdata;
      if (wr_cmp && reg_ix[0])
        cmp_ov[reg_ix[3:1]] <= wdata;
      if (wr_cmp && !reg_ix[0])
        cmp_uv[reg_ix[3:1]] <= wdata;
      if (wr_ctrl)
        ctrl <= wdata;
    end

  // Host commands; auto mode masks them out
  wire auto_en  = ctrl[CTRL_AUTO];
  wire op_on    = ctrl[CTRL_ON];
  wire op_soft  = ctrl[CTRL_SOFT];
  wire on_op    = auto_en | op_on;
  wire on_pin   = auto_en | host_control_pin;
  wire off_op   = !auto_en & !op_on;
  wire off_hard = off_op & !op_soft;
  wire off_pin  = !auto_en & !host_control_pin;

  // Converter result, clamped on the low-range pins
  wire [3:0] ch     = adc_in.ch;
  wire mon_ch       = adc_in.valid && ch < 4'(NMON);
  wire [3:0] ch_ix  = mon_ch ? ch : 4'h0;
  wire clamp_ch     = ch >= CLAMP_FIRST && ch < CLAMP_FIRST + 4'h4;
  wire [11:0] d     = (clamp_ch && adc_in.data < CLAMP_CODE)
                      ? CLAMP_CODE : adc_in.data;
  wire [31:0] mc    = mcfg[ch_ix];
  wire [1:0] m_type = mc[MC_TYPE +: 2];
  wire [3:0] m_rail = mc[MC_RAIL +: 4];

  // Mux walks all channels, sensor included, without pause
  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b)
      adc_sel <= '0;
    else if (adc_in.valid)
      adc_sel <= (ch >= 4'(NCH - 1)) ? 4'h0 : ch + 4'h1;

  // Fast comparators act on each conversion, not the loop
  wire [2:0] ci     = (ch < 4'(NCMP)) ? ch[2:0] : 3'h0;
  wire cmp_i        = mon_ch && ch < 4'(NCMP) && mc[MC_CMP]
                      && m_type == MT_VOLT;
  wire cmp_flt      = cmp_i && (d < cmp_uv[ci][11:0]
                      || d > cmp_ov[ci][11:0]);
  wire cmp_wrn      = cmp_i && (d < cmp_uv[ci][27:16]
                      || d > cmp_ov[ci][27:16]);

  // Warnings drive general outputs, one per comparator
  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b)
      general_output <= '0;
    else if (cmp_i)
      general_output[ci] <= cmp_wrn;

  // Sample store: voltage raw, current and temperature filtered
  logic [11:0] vraw  [NR];
  logic [11:0] ihist [NR][4];
  logic [11:0] thist [NR][4];
  logic [3:0]  cur_ptr;   // Rail whose current is due
  logic        cur_pend;  // Slot not yet served
  wire cur_take = mon_ch && m_type == MT_CUR && m_rail == cur_ptr
                  && cur_pend;

  // One process owns every sample array
  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b)
    begin
      for (int i = 0; i < NR; i++)
      begin
        vraw[i] <= '0;
        for (int k = 0; k < 4; k++)
        begin
          ihist[i][k] <= '0;
          thist[i][k] <= '0;
        end
      end
      cur_ptr  <= '0;
      cur_pend <= 1'b0;
    end
    else
    begin
      // Tick wins over take, so no slot is dropped
      if (cur_tick)
      begin
        cur_pend <= 1'b1;
        cur_ptr  <= (cur_ptr >= 4'(NR - 1)) ? 4'h0 : cur_ptr + 4'h1;
      end
      else if (cur_take)
        cur_pend <= 1'b0;
      if (mon_ch && m_rail < 4'(NR))
        case (m_type)
          MT_VOLT: vraw[m_rail] <= d;
          MT_CUR:
            if (cur_take)
              ihist[m_rail] <= '{d, ihist[m_rail][0],
                                 ihist[m_rail][1], ihist[m_rail][2]};
          MT_TEMP:
            thist[m_rail] <= '{d, thist[m_rail][0],
                               thist[m_rail][1], thist[m_rail][2]};
          default: ;
        endcase
    end

  // Per-rail state
  rsm_state_t  state [NR];
  logic [15:0] cnt   [NR];  // Milliseconds in this state
  logic [3:0]  flt   [NR];  // hw, uc, oc, turn-on timeout
  logic [11:0] iavg  [NR];
  logic [11:0] tavg  [NR];
  logic [NR-1:0] pg_vec;    // Rail in regulation
  logic [NR-1:0] flt_any;
  logic [NR-1:0] ocw;       // Overcurrent warning, live

  genvar r;
  generate
    for (r = 0; r < NR; r++)
    begin : g_rail
      rsm_cfg_t cfg;
      rsm_state_t next_state;
      logic next_en;
      assign cfg = rreg[r][R_CFG];
      wire vmon = cfg.vmon;
      wire [NR-1:0] par = rreg[r][R_LINK][NR-1:0];
      wire [NR-1:0] slv = rreg[r][R_LINK][16 +: NR];
      wire [15:0] dly_on  = {4'h0, rreg[r][R_DLY][11:0]};
      wire [15:0] dly_off = {4'h0, rreg[r][R_DLY][27:16]};
      wire [15:0] ton  = dly_on > MAX_DLY_MS ? MAX_DLY_MS : dly_on;
      wire [15:0] toff = dly_off > MAX_DLY_MS ? MAX_DLY_MS : dly_off;
      wire [15:0] ton_max  = rreg[r][R_LIM][15:0];
      wire [15:0] toff_max = rreg[r][R_LIM][31:16];
      wire [13:0] isum = 14'(ihist[r][0]) + 14'(ihist[r][1])
                       + 14'(ihist[r][2]) + 14'(ihist[r][3]);
      wire [13:0] tsum = 14'(thist[r][0]) + 14'(thist[r][1])
                       + 14'(thist[r][2]) + 14'(thist[r][3]);
      assign iavg[r] = isum[13:2];
      assign tavg[r] = tsum[13:2];

      // Conditions
      wire gin_hit = general_input[cfg.gin_sel] == cfg.gin_lvl;
      wire par_up  = &(pg_vec | ~par);
      wire par_dn  = |(~pg_vec & par);
      wire [3:0] on_met = {gin_hit, par_up, on_pin, on_op};
      wire on_ok = |cfg.on_trig
                   && &(on_met | ~cfg.on_trig);
      wire slv_flt = |(flt_any & slv);
      wire [5:0] off_met = {!gin_hit, slv_flt, flt_any[r], par_dn,
                            off_pin, off_op};
      wire off_ev = |(cfg.off_trig & off_met);
      wire imm = cfg.imm_off
                 | (off_hard & cfg.off_trig[OFF_OP]);
      wire hw_trip = cmp_flt && m_rail == 4'(r);

      // Faults; zero limit never times out
      wire to_flt = vmon && state[r] == S_RAMP && ton_max != 16'h0
                    && cnt[r] >= ton_max;
      wire uc_en = vmon ? state[r] == S_ON
                   : state[r] == S_RAMP || state[r] == S_ON;
      wire oc_f = state[r] != S_OFF
                  && iavg[r] > rreg[r][R_ILIM][11:0];
      wire uc_f = uc_en && iavg[r] < rreg[r][R_ILIM][27:16];
      wire [3:0] flt_set = {hw_trip, uc_f, oc_f, to_flt};
      wire flt_clr = state[r] == S_OFF && next_state == S_ONDLY;

      // Next state; comparator trip needs no sample tick
      always_comb
      begin
        next_state = state[r];
        next_en    = rail_en[r];
        if (hw_trip)
        begin
          next_state = S_FALL;
          next_en    = 1'b0;
        end
        else if (tick)
          case (state[r])
            S_OFF:
              if (on_ok && !off_ev)
                next_state = S_ONDLY;
            S_ONDLY:
              if (off_ev)
                next_state = S_OFF;
              else if (cnt[r] >= ton)
              begin
                next_state = S_RAMP;
                next_en    = 1'b1;
              end
            S_RAMP, S_ON:
              if (off_ev && imm)
              begin
                next_state = S_FALL;
                next_en    = 1'b0;
              end
              else if (off_ev)
                next_state = S_OFFDLY;
              else if (state[r] == S_RAMP
                       && (vmon ? pg_vec[r] : cnt[r] >= ton_max))
                next_state = S_ON;
            S_OFFDLY:
              if (cnt[r] >= toff)
              begin
                next_state = S_FALL;
                next_en    = 1'b0;
              end
            S_FALL:
              if (vmon ? !pg_vec[r] : cnt[r] >= toff_max)
                next_state = S_OFF;
            default:
              next_state = S_OFF;
          endcase
      end

      // Rail flops; set beats clear on faults
      always_ff @(posedge ref_clk or negedge rst_b)
        if (!rst_b)
        begin
          state[r]   <= S_OFF;
          cnt[r]     <= '0;
          rail_en[r] <= 1'b0;
          flt[r]     <= '0;
          pg_vec[r]  <= 1'b0;
          flt_any[r] <= 1'b0;
          ocw[r]     <= 1'b0;
        end
        else
        begin
          state[r]   <= next_state;
          rail_en[r] <= next_en;
          if (next_state != state[r])
            cnt[r] <= '0;
          else if (ms_tick && cnt[r] != 16'hffff)
            cnt[r] <= cnt[r] + 16'h1;
          flt[r]     <= (flt_clr ? 4'h0 : flt[r]) | flt_set;
          flt_any[r] <= |flt[r];
          ocw[r]     <= state[r] != S_OFF
                        && iavg[r] > rreg[r][R_IWARN][11:0];
          if (!vmon)
            pg_vec[r] <= state[r] == S_ON || state[r] == S_OFFDLY
                         || state[r] == S_FALL;
          else if (vraw[r] >= rreg[r][R_PG][11:0])
            pg_vec[r] <= 1'b1;
          else if (vraw[r] < rreg[r][R_PG][27:16])
            pg_vec[r] <= 1'b0;
        end

      sequence en_rise;
        !rail_en[r] ##1 rail_en[r];
      endsequence
      sequence fall_done;
        state[r] == S_FALL && tick && !hw_trip && cnt[r] >= toff_max;
      endsequence

      pg_hold_a: assert property (vmon && pg_vec[r]
        && vraw[r] >= rreg[r][R_PG][27:16] |=> pg_vec[r])
        else $error("power good dropped above off limit");
      nv_on_a: assert property (!vmon && state[r] == S_RAMP
        && tick && !hw_trip && !off_ev && cnt[r] >= ton_max
        |=> state[r] == S_ON ##1 pg_vec[r])
        else $error("unmonitored rail not on in time");
      nv_off_a: assert property (!vmon and fall_done
        |=> state[r] == S_OFF ##1 !pg_vec[r])
        else $error("unmonitored rail not off in time");
      auto_on_a: assert property (auto_en
        && |cfg.on_trig && cfg.on_trig[3:2] == 2'h0 |-> on_ok)
        else $error("auto mode did not override controls");
      max_dly_a: assert property (state[r] == S_ONDLY && tick
        && !hw_trip && !off_ev && cnt[r] >= MAX_DLY_MS
        |=> state[r] == S_RAMP && rail_en[r])
        else $error("turn-on delay exceeded maximum");
      no_limit_a: assert property (ton_max == 16'h0
        |-> !to_flt)
        else $error("zero turn-on limit raised timeout");
      imm_off_a: assert property (state[r] == S_ON && tick
        && off_ev && imm |=> !rail_en[r] && state[r] == S_FALL)
        else $error("immediate turn-off not taken");
      trip_a: assert property (hw_trip
        |=> !rail_en[r] ##1 (state[r] != S_RAMP))
        else $error("comparator fault did not shut rail");
      step_a: assert property (en_rise
        |-> $past(tick) && $past(state[r]) == S_ONDLY)
        else $error("enable rose outside a sample step");
    end
  endgenerate

  clamp_a: assert property (mon_ch && clamp_ch
    |-> d >= CLAMP_CODE)
    else $error("low-range input below clamp");

  // Readback of measurements for the addressed rail
  wire [31:0] vscl   = rreg[rail_ix][R_VSCL];
  wire [27:0] vprod  = 28'(vraw[rail_ix]) * 28'(vscl[15:0]);
  wire [15:0] vout   = 16'(vprod >> vscl[18:16]);
  wire [31:0] ical   = rreg[rail_ix][R_ICAL];
  wire [31:0] iuv    = 32'(iavg[rail_ix]) * 32'(LSB_UV);
  wire [31:0] ima    = ical[15:0] == 16'h0 ? 32'hffff_ffff
                       : iuv / 32'(ical[15:0]);
  wire [15:0] iout   = 16'(ima) - ical[31:16];
  wire [31:0] rstat  = {10'h0, tavg[rail_ix], ocw[rail_ix],
                        flt[rail_ix], pg_vec[rail_ix],
                        rail_en[rail_ix], state[rail_ix]};
  logic [31:0] rd_val;

  // Read data selection
  always_comb
  begin
    rd_val = '0;
    if (rail_hit)
      case (reg_ix)
        R_STAT:  rd_val = rstat;
        R_VOUT:  rd_val = {16'h0, vout};
        R_IOUT:  rd_val = {16'h0, iout};
        default:
          if (reg_ix < 4'(NUM_RW))
            rd_val = rreg[rail_ix][reg_ix];
      endcase
    else if (bank == B_MON && reg_ix < 4'(NMON))
      rd_val = mcfg[reg_ix];
    else if (bank == B_CMP && reg_ix < 4'(2 * NCMP))
      rd_val = reg_ix[0] ? cmp_ov[reg_ix[3:1]] : cmp_uv[reg_ix[3:1]];
    else if (bank == B_GLB && reg_ix == G_CTRL)
      rd_val = ctrl;
    else if (bank == B_GLB && reg_ix == G_STAT)
      rd_val = {16'(pg_vec), 16'(rail_en)};
  end

  // Data stand one cycle after the strobe, zero otherwise
  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b)
      rdata <= '0;
    else
      rdata <= rd ? rd_val : 32'h0;

endmodule
`default_nettype wire

// [tb/rsm_adc_model.sv]
`timescale 1ns/100ps
`default_nettype none
module rsm_adc_model (
  input  wire logic         ref_clk,
  input  wire logic         rst_b,
  input  wire logic [3:0]   adc_sel,
  output var rsm_pkg::rsm_adc_t adc_in
);
  import rsm_pkg::*;
  logic [1:0] div;  // Conversion pacing
  logic       fin;  // Result due this cycle
  assign fin = (div == 2'h3);
  // Fixed level seen on each input
  function automatic logic [11:0] code(input logic [3:0] c);
    case (c)
      4'h0:    code = 12'h400;
      4'h1:    code = 12'h123;
      4'h9:    code = 12'h010;
      default: code = 12'h800;
    endcase
  endfunction
  // Free-running converter, one result every four cycles
  // Data toggles between results so stale codes never look valid
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      div    <= 2'h0;
      adc_in <= '0;
    end
    else
    begin
      div          <= div + 2'h1;
      adc_in.valid <= fin;
      adc_in.ch    <= adc_sel;
      adc_in.data  <= fin ? code(adc_sel) : ~code(adc_sel);
    end
  end
endmodule
`default_nettype wire

// [tb/rsm_sequencer_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module rsm_sequencer_tb_top;
  import rsm_pkg::*;
  typedef struct packed
  {
    logic [7:0]  a;
    logic [31:0] w;
    logic [31:0] e;
  } rsm_row_t;
  logic        ref_clk = 1'b0;
  logic        rst_b = 1'b0;  // Held low at start
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        host_control_pin = 1'b0;
  logic [7:0]  general_input = 8'h00;
  logic [31:0] rdata;
  logic [3:0]  adc_sel;
  logic [9:0]  rail_en;
  logic [5:0]  general_output;
  logic [31:0] v;  // Last read word
  rsm_adc_t    adc_in;
  int          n_errors = 0;
  int          check_count = 0;
  // Write, read back: config, full delay fields, unmapped, parent link
  // Delay words keep what was written; the limit applies on use
  rsm_row_t rows [4] = '{
    '{8'h00, 32'h0000_0011, 32'h0000_0011},
    '{8'h02, 32'h0fff_0fff, 32'h0fff_0fff},
    '{8'hc5, 32'hffff_ffff, 32'h0000_0000},
    '{8'h21, 32'h0000_0001, 32'h0000_0001}};
  always #2 ref_clk = ~ref_clk;
  rsm_sequencer #(.SAMPLE_CYC(40), .CUR_CYC(20), .MS_CYC(8)) i_rsm_sequencer (
    .ref_clk(ref_clk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .host_control_pin(host_control_pin),
    .general_input(general_input), .adc_in(adc_in), .adc_sel(adc_sel),
    .rail_en(rail_en), .general_output(general_output));
  rsm_adc_model i_rsm_adc_model (
    .ref_clk(ref_clk), .rst_b(rst_b), .adc_sel(adc_sel), .adc_in(adc_in));
  // Verdict and end of run
  task conclude();
    if (n_errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One-cycle write strobe
  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  // Data only stands in the cycle after the strobe
  task rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Bounded wait for one enable, then compare
  task wait_en(input int i, input logic lv);
    int k;
    for (k = 0; k < 1000 && rail_en[i] !== lv; k++)
      @(negedge ref_clk);
    if (k == 1000)
    begin
      n_errors++;
      conclude();
    end
    else
      chk("rail_en bit", 32'(rail_en[i]), 32'(lv));
  endtask
  // Assign an input to a rail, scale it, compare reported voltage
  task vcheck(input logic [7:0] ca, input logic [31:0] cv,
              input logic [3:0] r, input logic [31:0] sc,
              input logic [31:0] ex);
    wr_reg(ca, cv);
    wr_reg({r, R_VSCL}, sc);
    repeat (200) @(posedge ref_clk);
    rd_reg({r, R_VOUT}, v);
    chk("reported voltage", v, ex);
  endtask
  initial
  begin
    repeat (4) @(posedge ref_clk);
    chk("enables in reset", {22'h0, rail_en}, 32'h0);  // [RESET]
    chk("read data in reset", rdata, 32'h0);  // [RESET]
    rst_b <= 1'b1;
    foreach (rows[i])
    begin
      wr_reg(rows[i].a, rows[i].w);
      rd_reg(rows[i].a, v);
      chk("register row", v, rows[i].e);
    end
    wr_reg(8'h02, 32'h0);
    wr_reg(8'h20, 32'h0000_0004);
    wr_reg(8'h10, 32'h0000_8022);
    // Operation on: rail 0 first, child rail 2 only after it
    wr_reg({B_GLB, G_CTRL}, 32'h2);
    wait_en(0, 1'b1);
    chk("child before parent", 32'(rail_en[2]), 32'h0);
    wait_en(2, 1'b1);
    rd_reg({B_GLB, G_STAT}, v);
    chk("unmonitored power good", 32'(v[16]), 32'h1);
    // Pin sequence on then off
    @(posedge ref_clk);
    host_control_pin <= 1'b1;
    wait_en(1, 1'b1);
    @(posedge ref_clk);
    host_control_pin <= 1'b0;
    wait_en(1, 1'b0);
    // Hard stop by operation
    wr_reg({B_GLB, G_CTRL}, 32'h0);
    wait_en(0, 1'b0);
    // Auto mode ignores the cleared on bit
    wr_reg(8'h30, 32'h0000_0001);
    wr_reg({B_GLB, G_CTRL}, 32'h1);
    wait_en(3, 1'b1);
    wait_en(0, 1'b1);
    // Fast undervoltage comparator on input 0 shuts rail 0
    // Over limits out of reach, so only the under limits can trip
    wr_reg({B_CMP, 4'h1}, 32'h0fff_0fff);
    wr_reg({B_CMP, 4'h0}, 32'h0900_0800);
    wr_reg({B_MON, 4'h0}, 32'h0000_0041);
    wait_en(0, 1'b0);
    chk("warning outputs", 32'(general_output), 32'h1);
    vcheck({B_MON, 4'h1}, 32'h11, 4'h4, 32'h0001_0003, 32'h1b4);
    vcheck({B_MON, 4'h9}, 32'h15, 4'h5, 32'h1,
           32'(CLAMP_CODE));
    // Input 2 as current of rail 6: gain 1000 mOhm, offset 0x10
    // Long wait, since a slot only takes a sample when input 2 lands in it
    wr_reg({B_MON, 4'h2}, 32'h0000_001a);
    wr_reg({4'h6, R_ICAL}, 32'h0010_03e8);
    repeat (4000) @(posedge ref_clk);
    rd_reg({4'h6, R_IOUT}, v);
    chk("reported current", v, 32'h0000_04d1);
    // Mux request steps past each result, sensor wraps to zero
    for (int k = 0; k < 8 && adc_in.valid !== 1'b1; k++)
      @(negedge ref_clk);
    v = 32'(adc_in.ch);
    @(negedge ref_clk);
    chk("mux channel", 32'(adc_sel),
        v == 32'hd ? 32'h0 : v + 32'h1);
    conclude();
  end
endmodule
`default_nettype wire
